/* File: shared/alj_pkg.sv */
package alj_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ALJ_OP_NONE,
        ALJ_OP_ADD_IMM_WORD,
        ALJ_OP_SUB_IMM_WORD,
        ALJ_OP_SUB_IMM_WITH_BORROW,
        ALJ_OP_AND_WITH_CONSTANT,
        ALJ_OP_OR_WITH_CONSTANT,
        ALJ_OP_ZERO_MINUS_CHECK,
        ALJ_OP_MASK_SET_BITS,
        ALJ_OP_MASK_CLEAR_BITS,
        ALJ_OP_MIXED_SIGN_MULTIPLY,
        ALJ_OP_FRACTIONAL_MIXED_MULTIPLY,
        ALJ_OP_POINTER_JUMP,
        ALJ_OP_EXTENDED_POINTER_JUMP
    } alj_op_e;

    // ------------------------------------------------------------
    // Status flag positions and widths
    // ------------------------------------------------------------
    localparam int FLAG_C  = 0;
    localparam int FLAG_Z  = 1;
    localparam int FLAG_N  = 2;
    localparam int FLAG_V  = 3;
    localparam int FLAG_S  = 4;
    localparam int FLAG_H  = 5;
    localparam int FLAG_W  = 6;
    localparam int PC_W    = 22;
    localparam int PC_LO_W = 16;
    localparam int PC_HI_W = 6;

    // ------------------------------------------------------------
    // Reset values and cycle costs
    // ------------------------------------------------------------
    localparam logic [5:0]  FLAGS_RST    = 6'h00;
    localparam logic [15:0] RESULT_RST   = 16'h0000;
    localparam logic [21:0] PC_RST       = 22'h000000;
    localparam logic [1:0]  CYC_ONE      = 2'h1;
    localparam logic [1:0]  CYC_TWO      = 2'h2;

endpackage : alj_pkg

/* File: src/alj_exec.sv */
`timescale 1ns/1ps
// Contract
// - Add-immediate-to-word adds a constant to a 16-bit pair, sets Z C N V S, keeps H, takes 2 cycles.
// - Subtract-immediate-from-word subtracts a constant from a pair, sets Z C N V S, keeps H, takes 2 cycles.
// - Subtract-immediate-with-borrow computes d minus K minus C, sets all six flags, takes 1 cycle.
// - AND with constant stores d AND K, sets Z N V S only, takes 1 cycle.
// - OR with constant stores d OR K, sets Z N V S only, takes 1 cycle.
// - Zero-minus check ANDs a register with itself and sets Z N V S in 1 cycle.
// - Mask-set-bits ORs a mask into the register, sets Z N V S, takes 1 cycle.
// - Mask-clear-bits ANDs with the complement of a mask, sets Z N V S, takes 1 cycle.
// - Mixed multiply forms signed by unsigned product into R1:R0, sets Z C only, takes 2 cycles.
// - Fractional mixed multiply shifts that product left one bit into R1:R0, sets Z C, 2 cycles.
// - Pointer jump loads PC 15:0 from the pointer pair and zeroes PC 21:16, no flags, 2 cycles.
// - Extended pointer jump loads PC 21:16 from the upper jump address, no flags, 2 cycles.

module alj_exec (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Issue
    input  wire logic                start,
    input  wire alj_pkg::alj_op_e    op,
    input  wire logic [15:0]         opd_a,
    input  wire logic [7:0]          opd_b,
    input  wire logic [15:0]         pointer_pair,
    input  wire logic [5:0]          upper_jump_address_reg,
    input  wire logic [5:0]          flags_in,
    // Results
    output logic                     busy,
    output logic                     done,
    output logic [15:0]              result,
    output logic                     result_wide,
    output logic                     result_to_r1r0,
    output logic                     result_write,
    output logic [5:0]               flags_out,
    output logic [21:0]              pc_out,
    output logic                     pc_load
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] logic_flags(input logic [7:0] r,
                                               input logic [5:0] f);
        logic [5:0] o;
        o = f;
        o[alj_pkg::FLAG_Z] = (r == 8'h00);
        o[alj_pkg::FLAG_N] = r[7];
        o[alj_pkg::FLAG_V] = 1'b0;
        o[alj_pkg::FLAG_S] = r[7];
        return o;
    endfunction : logic_flags

    function automatic logic [15:0] mixed_mul(input logic [7:0] a,
                                              input logic [7:0] b);
        logic signed [16:0] p;
        p = $signed({{9{a[7]}}, a}) * $signed({9'h000, b});
        return p[15:0];
    endfunction : mixed_mul

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0]  cnt_reg, cnt_next;
    logic        busy_reg, busy_next;
    logic        done_reg, done_next;
    logic [15:0] res_reg, res_next;
    logic        wide_reg, wide_next;
    logic        r1r0_reg, r1r0_next;
    logic        wr_reg, wr_next;
    logic [5:0]  flg_reg, flg_next;
    logic [21:0] pc_reg, pc_next;
    logic        pcl_reg, pcl_next;
    // Remembers whether the staged op loads the PC and writes back
    logic        pcl_stage, wr_stage;

    // Computed combinationally from the issue inputs; the registered copies are held until completion
    logic [15:0] c_res;
    logic [5:0]  c_flg;
    logic [21:0] c_pc;
    logic        c_wide, c_r1r0, c_wr, c_pcl;
    logic [1:0]  c_cyc;
    logic [16:0] wsum;
    logic [8:0]  bsub;
    logic [4:0]  hsub;
    logic [15:0] prod;
    logic [7:0]  r8;

    always_comb begin
        c_res  = alj_pkg::RESULT_RST;
        c_flg  = flags_in;
        c_pc   = alj_pkg::PC_RST;
        c_wide = 1'b0;
        c_r1r0 = 1'b0;
        c_wr   = 1'b0;
        c_pcl  = 1'b0;
        c_cyc  = alj_pkg::CYC_ONE;
        wsum   = 17'h00000;
        bsub   = 9'h000;
        hsub   = 5'h00;
        prod   = 16'h0000;
        r8     = 8'h00;
        unique case (op)
            alj_pkg::ALJ_OP_ADD_IMM_WORD: begin
                wsum  = {1'b0, opd_a} + {9'h000, opd_b};
                c_res = wsum[15:0];
                c_flg[alj_pkg::FLAG_C] = wsum[16];
                c_flg[alj_pkg::FLAG_V] = ~opd_a[15] & wsum[15];
                c_wide = 1'b1;
                c_wr   = 1'b1;
                c_cyc  = alj_pkg::CYC_TWO;
            end
            alj_pkg::ALJ_OP_SUB_IMM_WORD: begin
                wsum  = {1'b0, opd_a} - {9'h000, opd_b};
                c_res = wsum[15:0];
                c_flg[alj_pkg::FLAG_C] = wsum[16];
                c_flg[alj_pkg::FLAG_V] = opd_a[15] & ~wsum[15];
                c_wide = 1'b1;
                c_wr   = 1'b1;
                c_cyc  = alj_pkg::CYC_TWO;
            end
            alj_pkg::ALJ_OP_SUB_IMM_WITH_BORROW: begin
                bsub = {1'b0, opd_a[7:0]} - {1'b0, opd_b}
                     - {8'h00, flags_in[alj_pkg::FLAG_C]};
                hsub = {1'b0, opd_a[3:0]} - {1'b0, opd_b[3:0]}
                     - {4'h0, flags_in[alj_pkg::FLAG_C]};
                c_res = {8'h00, bsub[7:0]};
                c_flg[alj_pkg::FLAG_C] = bsub[8];
                c_flg[alj_pkg::FLAG_H] = hsub[4];
                c_flg[alj_pkg::FLAG_V] = (opd_a[7] & ~opd_b[7] & ~bsub[7])
                                       | (~opd_a[7] & opd_b[7] & bsub[7]);
                c_wr = 1'b1;
            end
            alj_pkg::ALJ_OP_AND_WITH_CONSTANT,
            alj_pkg::ALJ_OP_MASK_CLEAR_BITS: begin
                r8 = (op == alj_pkg::ALJ_OP_AND_WITH_CONSTANT)
                   ? (opd_a[7:0] & opd_b)
                   : (opd_a[7:0] & ~opd_b);
                c_res = {8'h00, r8};
                c_flg = logic_flags(r8, flags_in);
                c_wr  = 1'b1;
            end
            alj_pkg::ALJ_OP_OR_WITH_CONSTANT,
            alj_pkg::ALJ_OP_MASK_SET_BITS: begin
                r8    = opd_a[7:0] | opd_b;
                c_res = {8'h00, r8};
                c_flg = logic_flags(r8, flags_in);
                c_wr  = 1'b1;
            end
            alj_pkg::ALJ_OP_ZERO_MINUS_CHECK: begin
                r8    = opd_a[7:0] & opd_a[7:0];
                c_res = {8'h00, r8};
                c_flg = logic_flags(r8, flags_in);
                c_wr  = 1'b1;
            end
            alj_pkg::ALJ_OP_MIXED_SIGN_MULTIPLY,
            alj_pkg::ALJ_OP_FRACTIONAL_MIXED_MULTIPLY: begin
                prod = mixed_mul(opd_a[7:0], opd_b);
                c_flg[alj_pkg::FLAG_C] = prod[15];
                if (op == alj_pkg::ALJ_OP_FRACTIONAL_MIXED_MULTIPLY) begin
                    c_res = {prod[14:0], 1'b0};
                end else begin
                    c_res = prod;
                end
                c_flg[alj_pkg::FLAG_Z] = (c_res == 16'h0000);
                c_wide = 1'b1;
                c_r1r0 = 1'b1;
                c_wr   = 1'b1;
                c_cyc  = alj_pkg::CYC_TWO;
            end
            alj_pkg::ALJ_OP_POINTER_JUMP: begin
                c_pc  = {6'h00, pointer_pair};
                c_pcl = 1'b1;
                c_cyc = alj_pkg::CYC_TWO;
            end
            alj_pkg::ALJ_OP_EXTENDED_POINTER_JUMP: begin
                c_pc  = {upper_jump_address_reg, pointer_pair};
                c_pcl = 1'b1;
                c_cyc = alj_pkg::CYC_TWO;
            end
            default: begin
                c_cyc = alj_pkg::CYC_ONE;
            end
        endcase
        // Word add and subtract results take N and Z from all 16 bits
        if (c_wide && !c_r1r0) begin
            c_flg[alj_pkg::FLAG_Z] = (c_res == 16'h0000);
            c_flg[alj_pkg::FLAG_N] = c_res[15];
            c_flg[alj_pkg::FLAG_S] = c_res[15] ^ c_flg[alj_pkg::FLAG_V];
        end else if (!c_wide && c_wr
                     && op == alj_pkg::ALJ_OP_SUB_IMM_WITH_BORROW) begin
            c_flg[alj_pkg::FLAG_Z] = (bsub[7:0] == 8'h00);
            c_flg[alj_pkg::FLAG_N] = bsub[7];
            c_flg[alj_pkg::FLAG_S] = bsub[7] ^ c_flg[alj_pkg::FLAG_V];
        end
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    // Result, flags and PC are registered at issue; for two-cycle ops only the
    // done, write and PC-load strobes wait for the final cycle.
    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        res_next  = res_reg;
        wide_next = wide_reg;
        r1r0_next = r1r0_reg;
        wr_next   = 1'b0;
        flg_next  = flg_reg;
        pc_next   = pc_reg;
        pcl_next  = 1'b0;
        if (busy_reg) begin
            cnt_next = cnt_reg - 2'h1;
            if (cnt_reg == alj_pkg::CYC_ONE) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                wr_next   = wr_stage;
                pcl_next  = pcl_stage;
            end
        end else if (start && op != alj_pkg::ALJ_OP_NONE) begin
            res_next  = c_res;
            wide_next = c_wide;
            r1r0_next = c_r1r0;
            flg_next  = c_flg;
            pc_next   = c_pc;
            if (c_cyc == alj_pkg::CYC_ONE) begin
                done_next = 1'b1;
                wr_next   = c_wr;
            end else begin
                busy_next = 1'b1;
                cnt_next  = alj_pkg::CYC_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcl_stage <= 1'b0;
            wr_stage  <= 1'b0;
        end else if (!busy_reg && start) begin
            pcl_stage <= c_pcl;
            wr_stage  <= c_wr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg  <= 2'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            res_reg  <= alj_pkg::RESULT_RST;
            wide_reg <= 1'b0;
            r1r0_reg <= 1'b0;
            wr_reg   <= 1'b0;
            flg_reg  <= alj_pkg::FLAGS_RST;
            pc_reg   <= alj_pkg::PC_RST;
            pcl_reg  <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            res_reg  <= res_next;
            wide_reg <= wide_next;
            r1r0_reg <= r1r0_next;
            wr_reg   <= wr_next;
            flg_reg  <= flg_next;
            pc_reg   <= pc_next;
            pcl_reg  <= pcl_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy           = busy_reg;
    assign done           = done_reg;
    assign result         = res_reg;
    assign result_wide    = wide_reg;
    assign result_to_r1r0 = r1r0_reg;
    assign result_write   = wr_reg;
    assign flags_out      = flg_reg;
    assign pc_out         = pc_reg;
    assign pc_load        = pcl_reg;

endmodule : alj_exec

/* File: tb/alj_exec_sva.sv */
`timescale 1ns/1ps
module alj_exec_sva (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rstn,
    // Issue
    input wire logic             start,
    input wire alj_pkg::alj_op_e op,
    input wire logic [15:0]      pointer_pair,
    input wire logic [5:0]       upper_jump_address_reg,
    input wire logic [5:0]       flags_in,
    // Results
    input wire logic             busy,
    input wire logic             done,
    input wire logic             result_to_r1r0,
    input wire logic             result_write,
    input wire logic [5:0]       flags_out,
    input wire logic [21:0]      pc_out,
    input wire logic             pc_load
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Taken issue only; busy refuses and NONE is ignored
    logic iss, op_one, op_two, op_jmp;
    assign iss    = start && !busy && op != alj_pkg::ALJ_OP_NONE;
    assign op_one = op inside {[4'h3:4'h8]};
    assign op_two = op inside {4'h1, 4'h2, [4'h9:4'hC]};
    assign op_jmp = op inside {[4'hB:4'hC]};

    a_short_op_done:
        assert property (iss && op_one |=> done && !busy)
        else $error("single cycle op did not complete");
    a_long_op_busy:
        assert property (iss && op_two |=> busy && !done ##1 done && !busy)
        else $error("two cycle op timing wrong");
    a_plain_jump_target:
        assert property (iss && op == alj_pkg::ALJ_OP_POINTER_JUMP |=> ##1
            pc_load && pc_out == {6'h00, $past(pointer_pair, 2)})
        else $error("pointer jump target wrong");
    a_ext_jump_target:
        assert property (iss && op == alj_pkg::ALJ_OP_EXTENDED_POINTER_JUMP
            |=> ##1 pc_load && pc_out == {$past(upper_jump_address_reg, 2),
            $past(pointer_pair, 2)})
        else $error("extended jump target wrong");
    a_jump_keeps_flags:
        assert property (iss && op_jmp |=> ##1
            !result_write && flags_out == $past(flags_in, 2))
        else $error("jump changed flags or wrote a result");
    a_logic_keeps_ch:
        assert property (iss && op inside {[4'h4:4'h8]} |=>
            (flags_out & 6'h21) == ($past(flags_in) & 6'h21))
        else $error("logic op touched carry or half carry");
    a_mul_keeps_upper:
        assert property (iss && op inside {[4'h9:4'hA]} |=> ##1 result_to_r1r0
            && (flags_out & 6'h3C) == ($past(flags_in, 2) & 6'h3C))
        else $error("multiply touched flags beyond zero and carry");
    a_sign_is_xor:
        assert property (done && result_write && !result_to_r1r0 |->
            flags_out[4] == (flags_out[2] ^ flags_out[3]))
        else $error("sign flag is not negative xor overflow");

    c_ext_jump: cover property (pc_load && pc_out[21:16] != 6'h00);
    c_multiply: cover property (done && result_to_r1r0);
    c_write:    cover property (done && result_write && !result_to_r1r0);
endmodule : alj_exec_sva

bind alj_exec alj_exec_sva u_sva (.clk, .rstn, .start, .op, .pointer_pair,
    .upper_jump_address_reg, .flags_in, .busy, .done, .result_to_r1r0,
    .result_write, .flags_out, .pc_out, .pc_load);

/* File: tb/test_arith_logic_jump_exec.sv */
`timescale 1ns/1ps
module test_arith_logic_jump_exec;
    logic             clk, rstn, start, busy, done, result_wide, pc_load;
    logic             result_to_r1r0, result_write;
    alj_pkg::alj_op_e op;
    logic [15:0]      opd_a, pointer_pair, result;
    logic [7:0]       opd_b;
    logic [5:0]       upper_jump_address_reg, flags_in, flags_out;
    logic [21:0]      pc_out;
    int               n_errors, n_tests, seed;

    alj_exec dut (.clk, .rstn, .start, .op, .opd_a, .opd_b, .pointer_pair,
        .upper_jump_address_reg, .flags_in, .busy, .done, .result,
        .result_wide, .result_to_r1r0, .result_write, .flags_out,
        .pc_out, .pc_load);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // Model one op from integers, then drive it and compare at done
    task automatic run_op(input logic [3:0] o, input logic [15:0] a,
                          input logic [7:0] b, input logic [5:0] f);
        logic [16:0] w;
        logic [15:0] er;
        logic [8:0]  d;
        logic [4:0]  h;
        logic [5:0]  ef;
        logic [21:0] epc;
        logic        wide, r10, wr, pl;
        int          cyc, n;
        ef = f;
        er = 16'h0000;
        {wide, r10, wr, pl} = 4'h2;
        cyc = 2;
        case (o)
            4'h1, 4'h2: begin
                w = (o == 4'h1) ? a + b : a - b;
                er = w[15:0];
                ef[0] = w[16];
                ef[3] = (o == 4'h1) ? ~a[15] & er[15] : a[15] & ~er[15];
                wide = 1'b1;
            end
            4'h3: begin
                d = a[7:0] - b - f[0];
                h = a[3:0] - b[3:0] - f[0];
                er = {8'h00, d[7:0]};
                {ef[5], ef[3], ef[0]} = {h[4], (a[7]^b[7]) & (a[7]^d[7]), d[8]};
                cyc = 1;
            end
            4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
                er[7:0] = (o == 4'h4) ? a[7:0] & b : (o == 4'h8) ?
                    a[7:0] & ~b : (o == 4'h6) ? a[7:0] : a[7:0] | b;
                ef[3] = 1'b0;
                cyc = 1;
            end
            4'h9, 4'hA: begin
                er = {{8{a[7]}}, a[7:0]} * {8'h00, b};
                ef[0] = er[15];
                er = (o == 4'hA) ? er << 1 : er;
                ef[1] = (er == 16'h0000);
                r10 = 1'b1;
            end
            default: {wr, pl} = 2'b01;
        endcase
        if (wr && !r10)
            {ef[4], ef[2], ef[1]} = {(wide ? er[15] : er[7]) ^ ef[3],
                (wide ? er[15] : er[7]), er == 16'h0000};
        @(negedge clk);
        {start, opd_a, opd_b, flags_in} = {1'b1, a, b, f};
        op = alj_pkg::alj_op_e'(o);
        pointer_pair = 16'($random(seed));
        upper_jump_address_reg = 6'($random(seed));
        epc = {(o == 4'hC) ? upper_jump_address_reg : 6'h00, pointer_pair};
        @(negedge clk);
        start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 5) begin
            @(negedge clk);
            n++;
        end
        check(n == cyc, "latency");
        check(flags_out === ef, "flags");
        check({result_write, pc_load, result_to_r1r0} === {wr, pl, r10},
            "strobes");
        if (wr) check(result === er, "result");
        if (pl) check(pc_out === epc, "jump target");
        if (wr && !r10) check(result_wide === wide, "width");
    endtask : run_op

    initial begin
        logic [3:0] o;
        logic [7:0] b;
        {rstn, start, opd_a, opd_b, pointer_pair} = '0;
        {upper_jump_address_reg, flags_in} = '0;
        op = alj_pkg::ALJ_OP_NONE;
        seed = 75353;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        check({done, busy, pc_load, flags_out, result, pc_out} === '0, "reset");
        for (int i = 1; i < 13; i++) begin
            run_op(i[3:0], 16'hFFFF, 8'h3F, 6'h3F);
            run_op(i[3:0], 16'h8000, 8'h01, 6'h00);
            run_op(i[3:0], 16'h007F, 8'h00, 6'h21);
        end
        repeat (300) begin
            o = 4'h1 + 4'($unsigned($random(seed)) % 12);
            b = 8'($random(seed));
            if (o < 4'h3) b = b & 8'h3F;
            run_op(o, 16'($random(seed)), b, 6'($random(seed)));
        end
        // Start held while busy must be ignored
        @(negedge clk);
        {start, opd_a, opd_b, flags_in} = {1'b1, 16'h00FF, 8'h01, 6'h00};
        op = alj_pkg::ALJ_OP_ADD_IMM_WORD;
        @(negedge clk);
        op = alj_pkg::ALJ_OP_AND_WITH_CONSTANT;
        @(negedge clk);
        start = 1'b0;
        check(done === 1'b1 && result === 16'h0100, "word add");
        @(negedge clk);
        check(done === 1'b0 && result === 16'h0100, "refused op");
        // Reset in the middle of a jump clears done, busy, pc_load and pc_out
        start = 1'b1;
        op = alj_pkg::ALJ_OP_EXTENDED_POINTER_JUMP;
        @(negedge clk);
        {start, rstn} = 2'b00;
        #1 check({done, busy, pc_load, pc_out} === '0, "mid reset");
        @(negedge clk);
        rstn = 1'b1;
        run_op(4'h4, 16'h00F0, 8'h3C, 6'h21);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule : test_arith_logic_jump_exec
